/* File: rtl/host_system_if.sv */
// Purpose: Host system interface: bus width, byte order, banked registers,
//   buffer data port with FIFOs, DMA handshake, SRAM size and power down.
// Assumes: Host strobes are one-cycle pulses synchronous to i_clock.
// Notes: Function
// Function
// [RULE1] Buffer size bit picks 8 or 32 kbytes
// [RULE2] Power down after link disable, bit low
// [RULE3] Writing one or reset leaves power down
// [RULE4] Registers hold their value in power down
// [RULE5] Width bit one gives 8 bits
// [RULE6] Width indicator is inverse of width bit
// [RULE7] Reset enters 8-bit bus mode
// [RULE8] Swap word bytes when order bit set
// [RULE9] Swap only in 16-bit mode
// [RULE10] Swap only buffer port data, headers included
// [RULE11] Four sets of eight, byte or word
// [RULE12] Link control set always at 00H-07H
// [RULE13] Bank field maps one set at 08H
// [RULE14] Bank 10 presents buffer port at 08H
// [RULE15] Host normally leaves buffer set selected
// [RULE16] DMA acknowledge forces buffer port access
// [RULE17] Separate transmit and receive FIFOs, own pointers
// [RULE18] Word mode needs word buffer access
// [RULE19] Single and burst DMA by request/acknowledge
// [RULE20] End of process finishes cycle, stops DMA
// [RULE21] DMA interrupt when enabled and done
// [RULE22] One done flag, one request pair
// [RULE23] End of process sets done, stops requests
// [RULE24] Zero to DMA enable resets DMA logic
// [RULE25] Bank 00 node id, 01 hash, 11 reserved
`timescale 1ns/1ps
`default_nettype none
module host_system_if (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Host register bus
  input wire logic [3:0] i_addr,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_word,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  // DMA handshake
  output logic o_dma_request,
  input wire logic i_dma_acknowledge,
  input wire logic i_end_of_process,
  output logic o_irq,
  // Local buffer SRAM side
  output logic [14:0] o_buf_addr,
  output logic [7:0] o_buf_wdata,
  output logic o_buf_we,
  input wire logic [7:0] i_buf_rdata,
  // Status pins
  output logic o_width_indicator,
  output logic o_link_disable,
  output logic o_clock_stop
);
  logic [7:0] link_control_set [8];
  logic [7:0] node_id_set [8];
  logic [7:0] multicast_hash_set [8];
  logic [7:0] buf_port_set [8];
  logic [7:0] cfg_six;
  logic [7:0] cfg_seven;
  logic byte_mode;
  logic swap_on;
  logic [1:0] bank;
  logic port_hit;
  logic [2:0] idx;
  logic [15:0] port_wdata;
  logic [15:0] port_rdata;
  logic dma_running_reg;
  logic dma_done_flag_reg;
  logic [14:0] tx_ptr_reg;
  logic [14:0] rx_ptr_reg;
  logic [14:0] size_mask;
  logic tx_in_ready;
  logic tx_out_valid;
  logic [15:0] tx_out_data;
  logic rx_in_ready;
  logic rx_out_valid;
  logic [15:0] rx_out_data;
  logic rx_load_valid;
  logic [15:0] rx_load_data;
  logic tx_pop;
  logic rx_pop;
  logic high_phase_reg;
  // Word mode sends each transmit word as two bytes, this marks the second
  logic tx_high_reg;
  logic [7:0] rx_low_reg;
  logic rx_fill_phase_reg;

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_DOWN = 3'b010,
    PWR_WAKE = 3'b100
  } power_state_type;
  power_state_type power_reg;

  // Byte lanes of a buffer port word, swapped only in word mode
  function automatic logic [15:0] order_word(input logic [15:0] w, input logic sw);
    order_word = sw ? {w[7:0], w[15:8]} : w;
  endfunction

  assign cfg_six = link_control_set[6];
  assign cfg_seven = link_control_set[7];
  assign byte_mode = cfg_six[host_if_pkg::WIDTH_BIT]; // [RULE5]
  assign swap_on = cfg_seven[host_if_pkg::SWAP_BIT] && !byte_mode; // [RULE8] [RULE9]
  assign bank = cfg_seven[host_if_pkg::BANK_LSB +: 2];
  assign idx = i_addr[2:0];
  // [RULE14] [RULE16]
  assign port_hit = i_dma_acknowledge ||
    (i_addr == host_if_pkg::ADDR_DATA_PORT && bank == host_if_pkg::BANK_BUFFER);
  assign port_wdata = order_word(i_wdata, swap_on); // [RULE10]
  assign port_rdata = order_word(rx_out_data, swap_on); // [RULE10]
  // [RULE1]
  assign size_mask = cfg_six[host_if_pkg::BUF_SIZE_BIT] ?
    host_if_pkg::BUF_LARGE_MASK : host_if_pkg::BUF_SMALL_MASK;
  // Host pops a word in word mode, a byte pair on two reads in byte mode
  assign rx_pop = i_read && port_hit && power_reg == PWR_RUN &&
    (!byte_mode || high_phase_reg);

  // [RULE17] Transmit direction FIFO
  data_fifo #(.WIDTH(host_if_pkg::FIFO_WIDTH), .DEPTH(host_if_pkg::FIFO_DEPTH)) tx_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(i_write && port_hit && power_reg == PWR_RUN),
    .o_in_ready(tx_in_ready),
    .i_in_data(port_wdata),
    .o_out_valid(tx_out_valid),
    .i_out_ready(tx_pop),
    .o_out_data(tx_out_data)
  );

  // [RULE17] Receive direction FIFO
  data_fifo #(.WIDTH(host_if_pkg::FIFO_WIDTH), .DEPTH(host_if_pkg::FIFO_DEPTH)) rx_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(rx_load_valid),
    .o_in_ready(rx_in_ready),
    .i_in_data(rx_load_data),
    .o_out_valid(rx_out_valid),
    .i_out_ready(rx_pop),
    .o_out_data(rx_out_data)
  );

  // Power sequencing; registers are never touched by this process
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      power_reg <= PWR_RUN; // [RULE3]
    end else begin
      case (power_reg)
        PWR_RUN: begin
          // [RULE2]
          if (i_write && !port_hit && i_addr == host_if_pkg::ADDR_CFG_SEVEN &&
              !i_wdata[host_if_pkg::POWER_DOWN_N_BIT] &&
              cfg_six[host_if_pkg::LINK_DISABLE_BIT]) begin
            power_reg <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          if (i_write && !port_hit && i_addr == host_if_pkg::ADDR_CFG_SEVEN &&
              i_wdata[host_if_pkg::POWER_DOWN_N_BIT]) begin
            power_reg <= PWR_WAKE; // [RULE3]
          end
        end
        PWR_WAKE: power_reg <= PWR_RUN;
        default: power_reg <= PWR_RUN;
      endcase
    end
  end

  // Register file; power down leaves contents intact
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        link_control_set[i] <= 8'h00;
        node_id_set[i] <= 8'h00;
        multicast_hash_set[i] <= 8'h00;
        buf_port_set[i] <= 8'h00;
      end
      link_control_set[6] <= host_if_pkg::CFG_SIX_RESET; // [RULE7]
      link_control_set[7] <= host_if_pkg::CFG_SEVEN_RESET;
    end else if (i_write && !port_hit) begin
      // [RULE11] [RULE12] [RULE13] [RULE25]
      if (power_reg != PWR_RUN) begin
        // Only the wake bit acts while stopped [RULE4]
        if (i_addr == host_if_pkg::ADDR_CFG_SEVEN && i_wdata[host_if_pkg::POWER_DOWN_N_BIT]) begin
          link_control_set[7][host_if_pkg::POWER_DOWN_N_BIT] <= 1'b1;
        end
      end else if (!i_addr[3]) begin
        link_control_set[idx] <= i_wdata[7:0];
        if (i_word && !idx[0]) begin
          link_control_set[idx + 3'd1] <= i_wdata[15:8];
        end
      end else begin
        case (bank)
          host_if_pkg::BANK_NODE_ID: begin
            node_id_set[idx] <= i_wdata[7:0];
            if (i_word && !idx[0]) begin
              node_id_set[idx + 3'd1] <= i_wdata[15:8];
            end
          end
          host_if_pkg::BANK_HASH: begin
            multicast_hash_set[idx] <= i_wdata[7:0];
            if (i_word && !idx[0]) begin
              multicast_hash_set[idx + 3'd1] <= i_wdata[15:8];
            end
          end
          host_if_pkg::BANK_BUFFER: begin
            buf_port_set[idx] <= i_wdata[7:0];
            if (i_word && !idx[0]) begin
              buf_port_set[idx + 3'd1] <= i_wdata[15:8];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // DMA control; one done flag serves both directions
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dma_running_reg <= 1'b0;
      dma_done_flag_reg <= 1'b0;
    end else if (i_write && !port_hit && i_addr[3] && bank == host_if_pkg::BANK_BUFFER &&
                 idx == host_if_pkg::ADDR_DMA_ENABLE[2:0] && i_wdata[7:0] == 8'h00) begin
      dma_running_reg <= 1'b0; // [RULE24]
      dma_done_flag_reg <= 1'b0;
    end else begin
      if (i_dma_acknowledge && i_end_of_process && (i_read || i_write)) begin
        dma_done_flag_reg <= 1'b1; // [RULE20] [RULE23] [RULE22]
        dma_running_reg <= 1'b0;
      end else if (!dma_done_flag_reg &&
                   (buf_port_set[4][host_if_pkg::TX_DMA_EN_BIT] ||
                    buf_port_set[4][host_if_pkg::RX_DMA_EN_BIT])) begin
        dma_running_reg <= 1'b1;
      end
    end
  end

  // Request while the enabled direction can move data [RULE19]
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_dma_request <= 1'b0;
    end else begin
      o_dma_request <= dma_running_reg && !dma_done_flag_reg && power_reg == PWR_RUN &&
        !(i_end_of_process && i_dma_acknowledge) && // [RULE23]
        ((buf_port_set[4][host_if_pkg::TX_DMA_EN_BIT] && tx_in_ready) ||
         (buf_port_set[4][host_if_pkg::RX_DMA_EN_BIT] && rx_out_valid));
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= dma_done_flag_reg &&
        link_control_set[3][host_if_pkg::DMA_INT_EN_BIT]; // [RULE21]
    end
  end

  // Byte mode pairs two port reads into one FIFO word, low byte first
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !byte_mode) begin
      high_phase_reg <= 1'b0;
    end else if (i_read && port_hit && power_reg == PWR_RUN) begin
      high_phase_reg <= !high_phase_reg;
    end
  end

  // Host read data
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_read;
      if (i_read) begin
        if (port_hit) begin
          o_rdata <= byte_mode ?
            {8'h00, high_phase_reg ? rx_out_data[15:8] : rx_out_data[7:0]} : port_rdata;
        end else if (!i_addr[3]) begin
          o_rdata <= {link_control_set[idx | 3'd1], link_control_set[idx]};
          if (idx == host_if_pkg::ADDR_STATUS_ONE[2:0]) begin
            o_rdata <= {8'h00, 2'b00, dma_done_flag_reg, 5'h00};
          end
        end else begin
          case (bank)
            host_if_pkg::BANK_NODE_ID: o_rdata <= {node_id_set[idx | 3'd1], node_id_set[idx]};
            host_if_pkg::BANK_HASH: o_rdata <= {multicast_hash_set[idx | 3'd1],
                                                multicast_hash_set[idx]};
            host_if_pkg::BANK_BUFFER: o_rdata <= {buf_port_set[idx | 3'd1], buf_port_set[idx]};
            default: o_rdata <= 16'h0000;
          endcase
        end
        if (!i_word && !port_hit) begin
          o_rdata[15:8] <= 8'h00;
        end
      end
    end
  end

  // Buffer side: drain transmit FIFO and fill receive FIFO, one byte per cycle
  // A word leaves the FIFO on the same edge its last byte is sent to the buffer
  assign tx_pop = tx_out_valid && power_reg == PWR_RUN && (byte_mode || tx_high_reg);
  assign rx_load_valid = rx_fill_phase_reg && rx_in_ready;
  assign rx_load_data = {i_buf_rdata, rx_low_reg};

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tx_ptr_reg <= 15'h0000;
      rx_ptr_reg <= 15'h0000;
      rx_low_reg <= 8'h00;
      rx_fill_phase_reg <= 1'b0;
      tx_high_reg <= 1'b0;
      o_buf_addr <= 15'h0000;
      o_buf_wdata <= 8'h00;
      o_buf_we <= 1'b0;
    end else begin
      o_buf_we <= 1'b0;
      if (power_reg != PWR_RUN) begin
        o_buf_we <= 1'b0;
      end else if (tx_out_valid) begin
        // Transmit word written low byte then high in word mode, low byte only in byte mode, pointer wraps at size
        o_buf_addr <= tx_ptr_reg & size_mask; // [RULE17]
        o_buf_wdata <= tx_high_reg ? tx_out_data[15:8] : tx_out_data[7:0];
        o_buf_we <= 1'b1;
        tx_high_reg <= !byte_mode && !tx_high_reg;
        tx_ptr_reg <= (tx_ptr_reg + 15'd1) & size_mask;
      end else if (rx_in_ready) begin
        o_buf_addr <= rx_ptr_reg & size_mask;
        rx_low_reg <= i_buf_rdata;
        rx_fill_phase_reg <= !rx_fill_phase_reg;
        rx_ptr_reg <= (rx_ptr_reg + 15'd1) & size_mask;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_width_indicator <= 1'b0;
      o_link_disable <= 1'b0;
      o_clock_stop <= 1'b0;
    end else begin
      o_width_indicator <= !byte_mode; // [RULE6]
      o_link_disable <= cfg_six[host_if_pkg::LINK_DISABLE_BIT];
      o_clock_stop <= (power_reg == PWR_DOWN); // [RULE2]
    end
  end
endmodule
`default_nettype wire

/* File: rtl/host_if_pkg.sv */
// Purpose: Shared constants for the host system interface of the Ethernet controller.
// Assumes: Registers sit at the host addresses of a 16-address window.
// Notes: Bit positions follow the link control register layout.
package host_if_pkg;
  // Host address window
  localparam logic [3:0] ADDR_CFG_SIX = 4'h6;
  localparam logic [3:0] ADDR_CFG_SEVEN = 4'h7;
  localparam logic [3:0] ADDR_STATUS_ONE = 4'h1;
  localparam logic [3:0] ADDR_INT_ENABLE = 4'h3;
  localparam logic [3:0] ADDR_DATA_PORT = 4'h8;
  localparam logic [3:0] ADDR_DMA_ENABLE = 4'hc;
  // Field positions
  localparam int LINK_DISABLE_BIT = 7;
  localparam int WIDTH_BIT = 5;
  localparam int BUF_SIZE_BIT = 1;
  localparam int POWER_DOWN_N_BIT = 5;
  localparam int BANK_LSB = 2;
  localparam int SWAP_BIT = 0;
  localparam int DMA_DONE_BIT = 5;
  localparam int DMA_INT_EN_BIT = 5;
  localparam int TX_DMA_EN_BIT = 0;
  localparam int RX_DMA_EN_BIT = 1;
  // Bank codes
  localparam logic [1:0] BANK_NODE_ID = 2'h0;
  localparam logic [1:0] BANK_HASH = 2'h1;
  localparam logic [1:0] BANK_BUFFER = 2'h2;
  // Reset values: 8-bit mode, running, node id bank
  localparam logic [7:0] CFG_SIX_RESET = 8'h20;
  localparam logic [7:0] CFG_SEVEN_RESET = 8'h20;
  // Buffer sizes in bytes, address widths
  localparam int BUF_SMALL_BYTES = 8192;
  localparam int BUF_LARGE_BYTES = 32768;
  localparam int BUF_ADDR_W = 15;
  localparam logic [14:0] BUF_SMALL_MASK = 15'(BUF_SMALL_BYTES - 1);
  localparam logic [14:0] BUF_LARGE_MASK = 15'(BUF_LARGE_BYTES - 1);
  // Data FIFO
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 8;
endpackage

/* File: rtl/data_fifo.sv */
// Purpose: Synchronous valid/ready FIFO for buffer port data.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty come from a separate occupancy count.
`timescale 1ns/1ps
`default_nettype none
module data_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem[rd_ptr_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sram_model.sv */
// Purpose: Byte-wide packet SRAM at the far side of the buffer port.
// Assumes: Write pulse qualifies address and data on the same edge.
// Notes: Bytes never written read back as a toggling pattern, not a stale value.
`timescale 1ns/1ps
`default_nettype none
module sram_model (
  // Clock
  input wire logic i_clock,
  // Buffer side
  input wire logic [14:0] i_buf_addr,
  input wire logic [7:0] i_buf_wdata,
  input wire logic i_buf_we,
  output logic [7:0] o_buf_rdata
);
  // Sized for the large buffer so both size settings fit
  logic [7:0] mem [0:32767];
  logic [7:0] junk = 8'h55;
  always_ff @(posedge i_clock) begin
    junk <= ~junk;
    if (i_buf_we) begin
      mem[i_buf_addr] <= i_buf_wdata;
    end
    o_buf_rdata <= (^mem[i_buf_addr] === 1'bx) ? junk : mem[i_buf_addr];
  end
endmodule
`default_nettype wire

/* File: tb/host_system_if_assertions.sv */
// Purpose: Port-level checks of the host system interface.
// Assumes: Bank and interrupt enable are mirrored from host writes.
// Notes: Writes under acknowledge go to the data port, so mirrors skip them.
`timescale 1ns/1ps
`default_nettype none
module host_system_if_assertions (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Host bus
  input wire logic [3:0] i_addr,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_word,
  input wire logic [15:0] i_wdata,
  input wire logic o_rvalid,
  // DMA and status
  input wire logic o_dma_request,
  input wire logic i_dma_acknowledge,
  input wire logic i_end_of_process,
  input wire logic o_irq,
  input wire logic o_width_indicator,
  input wire logic o_link_disable,
  input wire logic o_clock_stop
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic reg_wr;
  logic [1:0] bank_reg;
  logic ie_reg;
  assign reg_wr = i_write && !i_dma_acknowledge && !o_clock_stop;
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      bank_reg <= host_if_pkg::BANK_NODE_ID;
    end else if (reg_wr && i_addr == host_if_pkg::ADDR_CFG_SEVEN) begin
      bank_reg <= i_wdata[3:2];
    end else if (reg_wr && i_word && i_addr == host_if_pkg::ADDR_CFG_SIX) begin
      bank_reg <= i_wdata[11:10];
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ie_reg <= 1'b0;
    end else if (reg_wr && i_addr == host_if_pkg::ADDR_INT_ENABLE) begin
      ie_reg <= i_wdata[5];
    end
  end
  sequence eop_hit;
    i_dma_acknowledge && i_end_of_process && (i_write || i_read);
  endsequence
  sequence dma_off;
    reg_wr && bank_reg == host_if_pkg::BANK_BUFFER
      && i_addr == host_if_pkg::ADDR_DMA_ENABLE && i_wdata[7:0] == 8'h00;
  endsequence
  sequence cfg_wr;
    reg_wr && i_addr == host_if_pkg::ADDR_CFG_SIX;
  endsequence
  sequence seven_wr;
    i_write && !i_dma_acknowledge && i_addr == host_if_pkg::ADDR_CFG_SEVEN;
  endsequence
  AST_READ_ANSWER: assert property (i_read && !o_clock_stop |=> o_rvalid)
    else $error("read not answered");
  AST_NO_STRAY: assert property (!i_read |=> !o_rvalid)
    else $error("answer without read");
  AST_RESET_STATE: assert property ($fell(i_sys_rst) |-> !o_width_indicator
    && !o_clock_stop && !o_irq && !o_dma_request) else $error("bad state after reset");
  AST_EOP_STOP: assert property (eop_hit |=> !o_dma_request[*2])
    else $error("request after end of process");
  AST_EOP_IRQ: assert property (eop_hit |-> ##2 (o_irq == $past(ie_reg, 2)))
    else $error("interrupt wrong after end of process");
  AST_DMA_CLOSE: assert property (dma_off |-> ##2 (!o_irq && !o_dma_request))
    else $error("dma not closed");
  AST_WIDTH_PIN: assert property (cfg_wr |-> ##2 (o_width_indicator == !$past(i_wdata[5], 2)
    && o_link_disable == $past(i_wdata[7], 2))) else $error("width or link pin wrong");
  AST_PD_ENTER: assert property (seven_wr ##0 !i_wdata[5] && o_link_disable
    && !o_clock_stop |-> ##[1:3] o_clock_stop) else $error("power down not entered");
  AST_PD_WAKE: assert property (seven_wr ##0 i_wdata[5] && o_clock_stop
    |-> ##[1:3] !o_clock_stop) else $error("power down not left");
  AST_PD_HOLD: assert property (o_clock_stop && !i_write |=> $stable(o_width_indicator)
    && $stable(o_link_disable)) else $error("state moved in power down");
endmodule
bind host_system_if host_system_if_assertions chk_u (.*);
`default_nettype wire

/* File: tb/ethernet_host_system_interface_tb.sv */
// Purpose: Self-checking bench of the host system interface.
// Assumes: Strobes are one cycle wide, driven on the falling edge.
// Notes: Expected reads and buffer bytes are queued by the driver.
`timescale 1ns/1ps
`default_nettype none
module ethernet_host_system_interface_tb;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic i_word = 1'b0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_dma_acknowledge = 1'b0;
  logic i_end_of_process = 1'b0;
  logic [15:0] o_rdata;
  logic o_rvalid, o_dma_request, o_irq, o_buf_we;
  logic o_width_indicator, o_link_disable, o_clock_stop;
  logic [14:0] o_buf_addr;
  logic [7:0] o_buf_wdata, i_buf_rdata;
  logic [31:0] rq[$];
  logic [7:0] wq[$];
  logic [7:0] bv [4];
  logic [15:0] d;
  int err_total = 0;
  int comparisons = 0;
  always #2.5 i_clock = ~i_clock;
  host_system_if dut_u (.*);
  sram_model mem_u (.i_clock(i_clock), .i_buf_addr(o_buf_addr), .i_buf_wdata(o_buf_wdata),
    .i_buf_we(o_buf_we), .o_buf_rdata(i_buf_rdata));
  task automatic fail(input string s);
    err_total++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task automatic chk_rd(input logic [15:0] g, input logic [31:0] n);
    comparisons++;
    if ((g & n[15:0]) !== n[31:16]) fail("read data");
  endtask
  task automatic chk_byte(input logic [7:0] g, e);
    comparisons++;
    if (g !== e) fail("buffer byte");
  endtask
  task automatic chk_pin(input logic g, e);
    comparisons++;
    if (g !== e) fail("status pin");
  endtask
  task automatic bus(input logic [3:0] a, input logic [15:0] v, input logic w, r, ack, eop);
    i_addr <= a;
    i_wdata <= v;
    i_word <= w;
    i_read <= r;
    i_write <= !r;
    i_dma_acknowledge <= ack;
    i_end_of_process <= eop;
    @(negedge i_clock);
    i_read <= 1'b0;
    i_write <= 1'b0;
    i_dma_acknowledge <= 1'b0;
    i_end_of_process <= 1'b0;
    @(negedge i_clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v, input logic w);
    bus(a, v, w, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic w, input logic [15:0] e, m);
    rq.push_back({e & m, m});
    bus(a, 16'h0000, w, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic wait_req;
    int n = 0;
    while (o_dma_request !== 1'b1 && n < 100) begin
      @(negedge i_clock);
      n++;
    end
    if (n == 100) fail("no dma request");
  endtask
  task automatic report_and_stop;
    if (rq.size() + wq.size() != 0) fail("results missing");
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(negedge i_clock) begin
    if (o_rvalid === 1'b1) begin
      if (rq.size() == 0) fail("stray read");
      else chk_rd(o_rdata, rq.pop_front());
    end
    if (o_buf_we === 1'b1) begin
      if (wq.size() == 0) fail("stray byte");
      else chk_byte(o_buf_wdata, wq.pop_front());
    end
  end
  initial begin
    void'($urandom(32'hae9f4f85));
    repeat (20) @(negedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    chk_pin(o_width_indicator, 1'b0);
    rd(4'h6, 1'b0, 16'h0020, 16'h00ff);
    for (int b = 0; b < 4; b++) begin
      bv[b] = 8'($urandom);
      wr(4'h7, 16'h0020 | 16'(b << 2), 1'b0);
      if (b != 2) wr(4'h8, {8'h00, bv[b]}, 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      wr(4'h7, 16'h0020 | 16'(b << 2), 1'b0);
      if (b != 2) rd(4'h8, 1'b0, (b == 3) ? 16'h0000 : {8'h00, bv[b]}, 16'h00ff);
      rd(4'h6, 1'b0, 16'h0020, 16'h00ff);
    end
    wr(4'h7, 16'h0028, 1'b0);
    d = 16'($urandom);
    wq.push_back(d[7:0]);
    wr(4'h8, d, 1'b0);
    wr(4'h6, 16'h0000, 1'b0);
    repeat (2) @(negedge i_clock);
    chk_pin(o_width_indicator, 1'b1);
    for (int s = 0; s < 2; s++) begin
      wr(4'h7, 16'h0028 | 16'(s), 1'b0);
      d = 16'($urandom);
      wq.push_back(s ? d[15:8] : d[7:0]);
      wq.push_back(s ? d[7:0] : d[15:8]);
      wr(4'h8, d, 1'b1);
    end
    rd(4'h6, 1'b1, 16'h2900, 16'hffff);
    wr(4'h6, 16'h0020, 1'b0);
    d = 16'($urandom);
    wq.push_back(d[7:0]);
    wr(4'h8, d, 1'b0);
    wr(4'h3, 16'h0020, 1'b0);
    wr(4'hc, 16'h0001, 1'b0);
    wr(4'h7, 16'h0020, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wait_req;
      d = 16'($urandom);
      wq.push_back(d[7:0]);
      bus(4'h0, d, 1'b0, 1'b0, 1'b1, k == 3);
    end
    @(negedge i_clock);
    chk_pin(o_dma_request, 1'b0);
    chk_pin(o_irq, 1'b1);
    rd(4'h1, 1'b0, 16'h0020, 16'h0020);
    wr(4'h7, 16'h0028, 1'b0);
    wr(4'hc, 16'h0000, 1'b0);
    @(negedge i_clock);
    chk_pin(o_irq, 1'b0);
    rd(4'h1, 1'b0, 16'h0000, 16'h0020);
    wr(4'h6, 16'h00a0, 1'b0);
    chk_pin(o_link_disable, 1'b1);
    wr(4'h7, 16'h0008, 1'b0);
    repeat (2) @(negedge i_clock);
    chk_pin(o_clock_stop, 1'b1);
    wr(4'h3, 16'h0000, 1'b0);
    wr(4'h7, 16'h0028, 1'b0);
    repeat (3) @(negedge i_clock);
    chk_pin(o_clock_stop, 1'b0);
    rd(4'h3, 1'b0, 16'h0020, 16'h00ff);
    rd(4'h6, 1'b0, 16'h00a0, 16'h00ff);
    repeat (30) @(negedge i_clock);
    report_and_stop;
  end
  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    fail("timeout");
    report_and_stop;
  end
endmodule
`default_nettype wire
